// ==== logic/bbc_map_ram.sv ====
// Purpose: one-bit-wide map of enabled region/32KB block pairs
// Assumes: single clock, write and read may share a cycle
// Notes: read data comes from a register, one cycle after the address
`default_nettype none
module bbc_map_ram (
   input wire logic clock, // system clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic wr_en, // write strobe
   input wire logic [bbc_pkg::MAP_AW-1:0] wr_addr, // write index
   input wire logic wr_data, // block enabled
   input wire logic [bbc_pkg::MAP_AW-1:0] rd_addr, // read index
   output logic rd_data // registered read data
);
   logic mem [bbc_pkg::MAP_DEPTH];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 1'b0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : bbc_map_ram
`default_nettype wire

// ==== logic/bbc_pkg.sv ====
// Purpose: shared constants for the bus break comparator
// Assumes: 125 MHz system clock
// Notes: select vector order is ce4..ce9, ext10, int10, ce3, wait port, busreq port
`default_nettype none
package bbc_pkg;
   localparam int NUM_SEL = 11;
   localparam int ACT_W = 12;
   localparam int NOSEL_BIT = 11;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;
   localparam int NUM_SET = 6;
   localparam int NUM_WIDE = 3;
   localparam int NUM_RANGE = 2;
   localparam int CNT_W = 16;
   localparam int STEP_W = 3;
   localparam logic [2:0] STEP_NONE = 3'h7;
   localparam int BLK_LSB = 15;
   localparam int BLK_W = ADDR_W - BLK_LSB;
   localparam int REG_IDX_W = 4;
   localparam int MAP_AW = REG_IDX_W + BLK_W;
   localparam int MAP_DEPTH = 1 << MAP_AW;
   localparam int DIR_RD = 0;
   localparam int DIR_WR = 1;
   localparam int CLK_NS = 8;
   localparam int BRK_PULSE_NS = 80;
   localparam int BRK_PULSE_CYC = (BRK_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PCNT_W = 4;
   localparam int SYNC_W = ADDR_W + DATA_W + NUM_SEL + 2;
endpackage : bbc_pkg
`default_nettype wire

// ==== logic/bbc_top.sv ====
// Purpose: break comparator watching the external bus of a 32-bit controller
// Assumes: bus pins asynchronous to clock; configuration ports quasi-static
// Notes: selects and strobes are active low on the pins
//
// Summary of operation
// - break on any access to an area whose select is chosen
// - several selects at once, plus optional no-select accesses
// - select and range breaks qualified by read, write or either
// - map break on a chosen 32KB block in a chosen region
// - map allows any number of region/block pairs together
// - six bus-condition sets, break when one is satisfied
// - address and data of each bus-condition set have their own masks
// - sets compare select, 24-bit address, data and direction
// - six sets for 16-bit data, three for 32-bit data
// - sequential mode breaks after enabled sets match in order
// - 16-bit hit counter, break when programmed count reached
// - one counter shared by all bus-condition sets
// - in sequential mode only the last set's matches count
// - range break inside or outside a programmed range, per unit
// - two independent range units
// - break pin floats when idle, pulses low on a break
// - monitor outputs high on each function's match, else low
// - no-select means access with every select and port line high
`default_nettype none
module bbc_top (
   input wire logic clock, // 125 MHz clock
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic [bbc_pkg::ADDR_W-1:0] bus_addr, // address pins
   input wire logic [bbc_pkg::DATA_W-1:0] bus_data, // data pins
   input wire logic [bbc_pkg::NUM_SEL-1:0] bus_sel_n, // area selects and port lines
   input wire logic bus_rd_n, // read strobe
   input wire logic bus_wr_n, // write strobe
   input wire logic ce_en, // select break enable
   input wire logic [bbc_pkg::ACT_W-1:0] ce_sel, // chosen selects, top bit no-select
   input wire logic [1:0] ce_dir, // bit0 read, bit1 write
   input wire logic map_en, // map break enable
   input wire logic map_wr_en, // map table write strobe
   input wire logic [bbc_pkg::MAP_AW-1:0] map_wr_addr, // region index and block
   input wire logic map_wr_data, // block enabled
   input wire logic [bbc_pkg::NUM_SET-1:0] bb_en, // set enables
   input wire logic bb_wide, // 32-bit data pairing
   input wire logic bb_seq, // sequential mode
   input wire logic [bbc_pkg::CNT_W-1:0] bb_count, // occurrences to break
   input wire logic [bbc_pkg::ACT_W-1:0] bb_sel [bbc_pkg::NUM_SET], // select pattern, zero ignores
   input wire logic [bbc_pkg::ADDR_W-1:0] bb_addr [bbc_pkg::NUM_SET], // address pattern
   input wire logic [bbc_pkg::ADDR_W-1:0] bb_amask [bbc_pkg::NUM_SET], // address mask, 1 ignores
   input wire logic [bbc_pkg::HALF_W-1:0] bb_data [bbc_pkg::NUM_SET], // data pattern
   input wire logic [bbc_pkg::HALF_W-1:0] bb_dmask [bbc_pkg::NUM_SET], // data mask, 1 ignores
   input wire logic [1:0] bb_dir [bbc_pkg::NUM_SET], // direction, zero ignores
   input wire logic [bbc_pkg::NUM_RANGE-1:0] rg_en, // range unit enables
   input wire logic [bbc_pkg::NUM_RANGE-1:0] rg_outside, // break outside the range
   input wire logic [bbc_pkg::ACT_W-1:0] rg_sel [bbc_pkg::NUM_RANGE], // chosen selects
   input wire logic [bbc_pkg::ADDR_W-1:0] rg_lo [bbc_pkg::NUM_RANGE], // lower bound, inclusive
   input wire logic [bbc_pkg::ADDR_W-1:0] rg_hi [bbc_pkg::NUM_RANGE], // upper bound, inclusive
   input wire logic [1:0] rg_dir [bbc_pkg::NUM_RANGE], // bit0 read, bit1 write
   output logic break_output_pin_o, // break pin level, always low
   output logic break_output_pin_oe, // break pin drive enable
   output logic ce_match_r, // select break match monitor
   output logic map_match_r, // map break match monitor
   output logic bus_match_r, // bus break match monitor
   output logic range_match_r // range break match monitor
);
   function automatic logic dir_ok(input logic [1:0] cfg, input logic rd, input logic wr);
      return (cfg[bbc_pkg::DIR_RD] & rd) | (cfg[bbc_pkg::DIR_WR] & wr);
   endfunction : dir_ok

   function automatic logic [2:0] first_from(input logic [5:0] en, input logic [3:0] start);
      logic [2:0] r;
      r = bbc_pkg::STEP_NONE;
      for (int k = 5; k >= 0; k--) begin
         if (en[k] && k >= int'(start)) begin
            r = 3'(k);
         end
      end
      return r;
   endfunction : first_from

   logic rst_s1_r, rst_sync_n;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_sync_n <= rst_s1_r;
      end
   end

   // three-stage pin capture; a change counts once stages two and three agree
   logic [bbc_pkg::SYNC_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_s1_r <= '1;
         pin_s2_r <= '1;
         pin_s3_r <= '1;
      end else begin
         pin_s1_r <= {bus_addr, bus_data, bus_sel_n, bus_rd_n, bus_wr_n};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   logic [bbc_pkg::ADDR_W-1:0] s_addr;
   logic [bbc_pkg::DATA_W-1:0] s_data;
   logic [bbc_pkg::NUM_SEL-1:0] s_sel_n;
   logic s_rd, s_wr, stable, in_cycle_r, ev, ev_d_r, rd_d_r, wr_d_r;
   logic [bbc_pkg::ACT_W-1:0] act;
   logic [bbc_pkg::REG_IDX_W-1:0] reg_idx;
   assign s_addr = pin_s3_r[bbc_pkg::SYNC_W-1 -: bbc_pkg::ADDR_W];
   assign s_data = pin_s3_r[bbc_pkg::DATA_W+bbc_pkg::NUM_SEL+1 -: bbc_pkg::DATA_W];
   assign s_sel_n = pin_s3_r[bbc_pkg::NUM_SEL+1 -: bbc_pkg::NUM_SEL];
   assign s_rd = ~pin_s3_r[1];
   assign s_wr = ~pin_s3_r[0];
   assign stable = (pin_s2_r == pin_s3_r);
   // port lines count toward no-select even when used as plain ports
   assign act = {&s_sel_n, ~s_sel_n};
   // one evaluation at the settled start of each access
   assign ev = stable & (s_rd | s_wr) & ~in_cycle_r;

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         in_cycle_r <= 1'b0;
      end else if (ev) begin
         in_cycle_r <= 1'b1;
      end else if (stable && !s_rd && !s_wr) begin
         in_cycle_r <= 1'b0;
      end
   end

   always_comb begin
      reg_idx = bbc_pkg::REG_IDX_W'(bbc_pkg::NOSEL_BIT);
      for (int k = bbc_pkg::NUM_SEL - 1; k >= 0; k--) begin
         if (act[k]) begin
            reg_idx = bbc_pkg::REG_IDX_W'(k);
         end
      end
   end

   logic map_bit;
   bbc_map_ram u_map (
      .clock(clock),
      .rst_n(rst_sync_n),
      .wr_en(map_wr_en),
      .wr_addr(map_wr_addr),
      .wr_data(map_wr_data),
      .rd_addr({reg_idx, s_addr[bbc_pkg::ADDR_W-1:bbc_pkg::BLK_LSB]}),
      .rd_data(map_bit)
   );

   logic ce_hit, map_hit, rg_hit;
   logic [bbc_pkg::NUM_SET-1:0] um, uen;
   assign ce_hit = ce_en & (|(act & ce_sel)) & dir_ok(ce_dir, s_rd, s_wr);
   // any number of pairs may be set in the table
   assign map_hit = map_en & ev_d_r & map_bit & (rd_d_r | wr_d_r);

   always_comb begin
      rg_hit = 1'b0;
      for (int r = 0; r < bbc_pkg::NUM_RANGE; r++) begin
         if (rg_en[r] && (|(act & rg_sel[r])) && dir_ok(rg_dir[r], s_rd, s_wr) &&
             (((s_addr >= rg_lo[r]) && (s_addr <= rg_hi[r])) != rg_outside[r])) begin
            rg_hit = 1'b1;
         end
      end
   end

   // wide mode pairs sets 2u and 2u+1 as low and high data halves
   always_comb begin
      int lo;
      lo = 0;
      um = '0;
      uen = '0;
      for (int u = 0; u < bbc_pkg::NUM_SET; u++) begin
         lo = bb_wide ? 2 * u : u;
         if (!bb_wide || u < bbc_pkg::NUM_WIDE) begin
            uen[u] = bb_en[lo];
            um[u] = ((bb_sel[lo] == '0) || (|(act & bb_sel[lo]))) &&
                    (((s_addr ^ bb_addr[lo]) & ~bb_amask[lo]) == '0) &&
                    (((s_data[bbc_pkg::HALF_W-1:0] ^ bb_data[lo]) & ~bb_dmask[lo]) == '0) &&
                    ((bb_dir[lo] == 2'h0) || dir_ok(bb_dir[lo], s_rd, s_wr));
            if (bb_wide) begin
               um[u] = um[u] &&
                       (((s_data[bbc_pkg::DATA_W-1:bbc_pkg::HALF_W] ^ bb_data[lo+1]) & ~bb_dmask[lo+1]) == '0);
            end
         end
      end
   end

   logic [bbc_pkg::STEP_W-1:0] step_r, cur, nxt;
   logic set_hit;
   logic [bbc_pkg::CNT_W-1:0] hits_r;
   logic bus_hit;
   assign cur = first_from(uen, {1'b0, step_r});
   assign nxt = first_from(uen, {1'b0, cur} + 4'h1);
   // sequential mode only counts when the last enabled set closes the chain
   assign set_hit = bb_seq ? (ev && cur != bbc_pkg::STEP_NONE && um[cur] && nxt == bbc_pkg::STEP_NONE)
                           : (ev && |(um & uen));
   assign bus_hit = set_hit && ((hits_r + 16'h0001) >= bb_count);

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         step_r <= '0;
      end else if (!bb_seq) begin
         step_r <= '0;
      end else if (ev && cur != bbc_pkg::STEP_NONE && um[cur]) begin
         step_r <= (nxt == bbc_pkg::STEP_NONE) ? '0 : nxt;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hits_r <= '0;
      end else if (bus_hit) begin
         hits_r <= '0;
      end else if (set_hit) begin
         hits_r <= hits_r + 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ev_d_r <= 1'b0;
         rd_d_r <= 1'b0;
         wr_d_r <= 1'b0;
      end else begin
         ev_d_r <= ev;
         rd_d_r <= s_rd;
         wr_d_r <= s_wr;
      end
   end

   // monitors hold their result until the next evaluation
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ce_match_r <= 1'b0;
         bus_match_r <= 1'b0;
         range_match_r <= 1'b0;
         map_match_r <= 1'b0;
      end else begin
         if (ev) begin
            ce_match_r <= ce_hit;
            bus_match_r <= bus_hit;
            range_match_r <= rg_hit;
         end
         if (ev_d_r) begin
            map_match_r <= map_hit;
         end
      end
   end

   // a break landing while pulse_r is nonzero merges with the pulse; one in its last cycle restarts and stretches it
   logic [bbc_pkg::PCNT_W-1:0] pulse_r;
   logic any_brk;
   assign any_brk = (ev & (ce_hit | bus_hit | rg_hit)) | map_hit;
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pulse_r <= '0;
         break_output_pin_oe <= 1'b0;
         break_output_pin_o <= 1'b0;
      end else begin
         break_output_pin_o <= 1'b0;
         if (any_brk && pulse_r == '0) begin
            pulse_r <= bbc_pkg::PCNT_W'(bbc_pkg::BRK_PULSE_CYC - 1);
            break_output_pin_oe <= 1'b1;
         end else if (pulse_r != '0) begin
            pulse_r <= pulse_r - 4'h1;
         end else begin
            break_output_pin_oe <= 1'b0;
         end
      end
   end

   // length of the current low pulse; a count instead of a long repetition keeps the checker small
   logic [bbc_pkg::PCNT_W-1:0] oe_len_r;
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         oe_len_r <= '0;
      end else if (break_output_pin_oe) begin
         oe_len_r <= oe_len_r + 4'h1;
      end else begin
         oe_len_r <= '0;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_n);

   sequence brk_start_s;
      $rose(break_output_pin_oe);
   endsequence

   chk_pulse_len: assert property (brk_start_s |-> ##9 (break_output_pin_oe &&
      oe_len_r == bbc_pkg::PCNT_W'(bbc_pkg::BRK_PULSE_CYC - 1)) ##1 !break_output_pin_oe)
      else $error("break pulse length wrong");
   chk_pin_low: assert property (break_output_pin_oe |-> !break_output_pin_o)
      else $error("break pin driven high");
   chk_ce_mon: assert property (ev |=> ce_match_r == $past(ce_hit))
      else $error("select monitor mismatch");
   chk_map_mon: assert property (ev_d_r |=> map_match_r == $past(map_en & map_bit & (rd_d_r | wr_d_r)))
      else $error("map monitor mismatch");
   chk_ce_break: assert property (ev && ce_hit && pulse_r == '0 |=> break_output_pin_oe)
      else $error("select hit without break");
   chk_one_eval: assert property (ev |=> !ev)
      else $error("two evaluations in one bus cycle");
   chk_count_clr: assert property (bus_hit |=> hits_r == '0)
      else $error("hit counter not cleared on break");
   chk_count_inc: assert property (set_hit && !bus_hit |=> hits_r == $past(hits_r) + 16'h0001)
      else $error("hit counter not advanced");
   chk_seq_hold: assert property (bb_seq && !ev |=> step_r == $past(step_r))
      else $error("sequence step moved without a bus cycle");
   chk_no_early: assert property (bb_seq && !set_hit |=> hits_r == $past(hits_r))
      else $error("sequential count moved before last set");
endmodule : bbc_top
`default_nettype wire

// ==== tb/bbc_bus_model.sv ====
// Purpose: bus master and debugger break receiver beside the comparator
// Assumes: one clock; the break line has a pull-up when nobody drives it
// Notes: released address and data lines show the inverse of the last value
`default_nettype none
module bbc_bus_model (
   input wire logic clock, // system clock
   input wire logic brk_o, // break pin level
   input wire logic brk_oe, // break pin drive enable
   output logic [23:0] bus_addr, // address pins
   output logic [31:0] bus_data, // data pins
   output logic [10:0] bus_sel_n, // select pins
   output logic bus_rd_n, // read strobe
   output logic bus_wr_n, // write strobe
   output int brk_pulses, // low pulses seen
   output int brk_width // last pulse width in cycles
);
   timeunit 1ns;
   timeprecision 1ps;
   logic brk_line;
   int low_cnt = 0;
   assign brk_line = brk_oe ? brk_o : 1'b1;
   initial begin
      {bus_addr, bus_data, brk_pulses, brk_width} = '0;
      {bus_sel_n, bus_rd_n, bus_wr_n} = '1;
   end
   always @(posedge clock) begin
      if (brk_line === 1'b0) begin
         low_cnt <= low_cnt + 1;
      end else begin
         if (low_cnt != 0) begin
            brk_pulses <= brk_pulses + 1;
            brk_width <= low_cnt;
         end
         low_cnt <= 0;
      end
   end
   // strobe held 8 clocks so the synchroniser sees settled pins
   task automatic cycle(input logic [23:0] a, input logic [31:0] d, input logic [10:0] s, input logic w);
      @(posedge clock);
      bus_addr <= a;
      bus_data <= d;
      bus_sel_n <= s;
      bus_rd_n <= w;
      bus_wr_n <= !w;
      repeat (8) @(posedge clock);
      {bus_sel_n, bus_rd_n, bus_wr_n} <= '1;
      bus_addr <= ~a;
      bus_data <= ~d;
      repeat (16) @(posedge clock);
   endtask : cycle
endmodule : bbc_bus_model
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the bus break comparator
// Assumes: one bus cycle at a time, 25 clocks each
// Notes: map entries that reads touch are written first; the table is not cleared
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [23:0] ba;
   logic [31:0] bd;
   logic [10:0] bs;
   logic brd, bwr, ce_en, map_en, mwe, mwd, bb_wide, bb_seq, bo, boe, cm, mm, bm, rm;
   logic [11:0] ce_sel;
   logic [1:0] ce_dir, rg_en, rg_out;
   logic [12:0] mwa;
   logic [5:0] bb_en;
   logic [15:0] bb_count;
   logic [11:0] bb_sel [6];
   logic [23:0] bb_addr [6];
   logic [23:0] bb_amask [6];
   logic [15:0] bb_data [6];
   logic [15:0] bb_dmask [6];
   logic [1:0] bb_dir [6];
   logic [11:0] rg_sel [2];
   logic [23:0] rg_lo [2];
   logic [23:0] rg_hi [2];
   logic [1:0] rg_dir [2];
   int num_errors = 0;
   int compares = 0;
   int pulses, width;
   logic [4:0] care = 5'h1F;
   always #4 clock = ~clock;
   bbc_top u_bbc_top (.clock(clock), .rst_n(rst_n), .bus_addr(ba), .bus_data(bd), .bus_sel_n(bs),
      .bus_rd_n(brd), .bus_wr_n(bwr), .ce_en(ce_en), .ce_sel(ce_sel), .ce_dir(ce_dir), .map_en(map_en),
      .map_wr_en(mwe), .map_wr_addr(mwa), .map_wr_data(mwd), .bb_en(bb_en), .bb_wide(bb_wide),
      .bb_seq(bb_seq), .bb_count(bb_count), .bb_sel(bb_sel), .bb_addr(bb_addr), .bb_amask(bb_amask),
      .bb_data(bb_data), .bb_dmask(bb_dmask), .bb_dir(bb_dir), .rg_en(rg_en), .rg_outside(rg_out),
      .rg_sel(rg_sel), .rg_lo(rg_lo), .rg_hi(rg_hi), .rg_dir(rg_dir), .break_output_pin_o(bo),
      .break_output_pin_oe(boe), .ce_match_r(cm), .map_match_r(mm), .bus_match_r(bm), .range_match_r(rm));
   bbc_bus_model u_bbc_bus_model (.clock(clock), .brk_o(bo), .brk_oe(boe), .bus_addr(ba), .bus_data(bd),
      .bus_sel_n(bs), .bus_rd_n(brd), .bus_wr_n(bwr), .brk_pulses(pulses), .brk_width(width));
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   // exp is {select, map, bus, range, one break pulse}; k of 11 means no select low
   task automatic run(input logic [23:0] a, input logic [31:0] d, input int k, input logic w, input logic [4:0] exp);
      int p0;
      p0 = pulses;
      u_bbc_bus_model.cycle(a, d, (k < 11) ? ~(11'h1 << k) : 11'h7FF, w);
      chk("flags", {cm, mm, bm, rm, pulses == p0 + 1} & care, exp & care);
   endtask : run
   task automatic map_wr(input logic [12:0] a, input logic v);
      @(posedge clock);
      mwe <= 1'b1;
      mwa <= a;
      mwd <= v;
      @(posedge clock);
      mwe <= 1'b0;
   endtask : map_wr
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk("reset", {boe, cm, mm, bm, rm}, 5'h00);
      rst_n <= 1'b1;
      repeat (8) @(posedge clock);
   endtask : do_reset
   task automatic finish_test;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   initial begin
      repeat (6000) @(posedge clock);
      num_errors++;
      finish_test();
   end
   initial begin
      {ce_en, map_en, mwe, mwd, bb_wide, bb_seq, ce_sel, ce_dir, rg_en, rg_out, mwa, bb_en, bb_count} <= '0;
      foreach (bb_sel[i]) {bb_sel[i], bb_addr[i], bb_amask[i], bb_data[i], bb_dmask[i], bb_dir[i]} <= '0;
      foreach (rg_sel[i]) {rg_sel[i], rg_lo[i], rg_hi[i], rg_dir[i]} <= '0;
      do_reset();
      ce_en <= 1'b1;
      ce_sel <= 12'h004;
      ce_dir <= 2'h1;
      run(24'h000010, 32'h0, 2, 1'b0, 5'h11);
      chk("width", width, bbc_pkg::BRK_PULSE_CYC);
      run(24'h000010, 32'h0, 2, 1'b1, 5'h00);
      ce_sel <= 12'h80C;
      ce_dir <= 2'h3;
      run(24'h000010, 32'h0, 3, 1'b1, 5'h11);
      run(24'h000010, 32'h0, 11, 1'b0, 5'h11);
      run(24'h000010, 32'h0, 10, 1'b0, 5'h00);
      $display("test select break done");
      ce_en <= 1'b0;
      map_en <= 1'b1;
      map_wr({4'h1, 9'h003}, 1'b1);
      map_wr({4'h1, 9'h004}, 1'b0);
      map_wr({4'h4, 9'h1FF}, 1'b1);
      run(24'h018000, 32'h0, 1, 1'b0, 5'h09);
      run(24'hFF8000, 32'h0, 4, 1'b1, 5'h09);
      run(24'h020000, 32'h0, 1, 1'b0, 5'h00);
      $display("test map break done");
      map_en <= 1'b0;
      bb_en <= 6'h01;
      bb_sel[0] <= 12'h001;
      bb_addr[0] <= 24'h123450;
      bb_amask[0] <= 24'h00000F;
      bb_data[0] <= 16'hA5A5;
      bb_dmask[0] <= 16'h00FF;
      bb_dir[0] <= 2'h2;
      bb_addr[5] <= 24'h000100;
      bb_dmask[5] <= 16'hFFFF;
      run(24'h12345A, 32'h0000A53C, 0, 1'b1, 5'h05);
      run(24'h123460, 32'h0000A53C, 0, 1'b1, 5'h00);
      run(24'h12345A, 32'h0000A43C, 0, 1'b1, 5'h00);
      run(24'h12345A, 32'h0000A53C, 0, 1'b0, 5'h00);
      run(24'h12345A, 32'h0000A53C, 1, 1'b1, 5'h00);
      bb_en <= 6'h21;
      run(24'h000100, 32'h0, 7, 1'b0, 5'h05);
      bb_count <= 16'h0003;
      care = 5'h01;
      run(24'h12345A, 32'h0000A53C, 0, 1'b1, 5'h00);
      run(24'h000100, 32'h0, 7, 1'b0, 5'h00);
      run(24'h12345A, 32'h0000A53C, 0, 1'b1, 5'h01);
      run(24'h000100, 32'h0, 7, 1'b0, 5'h00);
      $display("test bus break done");
      bb_seq <= 1'b1;
      bb_count <= 16'h0002;
      bb_en <= 6'h03;
      bb_addr[1] <= 24'h000200;
      bb_dmask[1] <= 16'hFFFF;
      do_reset();
      run(24'h000200, 32'h0, 7, 1'b0, 5'h00);
      run(24'h12345A, 32'h0000A53C, 0, 1'b1, 5'h00);
      run(24'h000300, 32'h0, 7, 1'b0, 5'h00);
      run(24'h000200, 32'h0, 7, 1'b0, 5'h00);
      run(24'h12345A, 32'h0000A53C, 0, 1'b1, 5'h00);
      run(24'h000200, 32'h0, 7, 1'b0, 5'h01);
      $display("test sequential break done");
      bb_seq <= 1'b0;
      bb_wide <= 1'b1;
      bb_en <= 6'h01;
      bb_count <= 16'h0001;
      bb_data[1] <= 16'h5A5A;
      bb_dmask[1] <= 16'h0000;
      care = 5'h1F;
      run(24'h12345A, 32'h5A5AA53C, 0, 1'b1, 5'h05);
      run(24'h12345A, 32'h5A5BA53C, 0, 1'b1, 5'h00);
      $display("test wide data done");
      bb_en <= 6'h00;
      bb_wide <= 1'b0;
      rg_en <= 2'h3;
      rg_out <= 2'h2;
      rg_sel[0] <= 12'h020;
      rg_lo[0] <= 24'h100000;
      rg_hi[0] <= 24'h1000FF;
      rg_dir[0] <= 2'h3;
      rg_sel[1] <= 12'h040;
      rg_lo[1] <= 24'h200000;
      rg_hi[1] <= 24'h2FFFFF;
      rg_dir[1] <= 2'h1;
      run(24'h100000, 32'h0, 5, 1'b1, 5'h03);
      run(24'h1000FF, 32'h0, 5, 1'b0, 5'h03);
      run(24'h100100, 32'h0, 5, 1'b0, 5'h00);
      run(24'h300000, 32'h0, 6, 1'b0, 5'h03);
      run(24'h300000, 32'h0, 6, 1'b1, 5'h00);
      run(24'h250000, 32'h0, 6, 1'b0, 5'h00);
      run(24'h300000, 32'h0, 5, 1'b0, 5'h00);
      $display("test range break done");
      finish_test();
   end
endmodule : tb
`default_nettype wire
